// *** hw/cppc_regs.svh ***
// constants for the pipeline and prefetch control block
`ifndef CPPC_REGS_SVH
`define CPPC_REGS_SVH

`define CPPC_WORD_W       32
`define CPPC_ENTRY_W      64
`define CPPC_PF_DEPTH     4
`define CPPC_PF_PTR_W     2
`define CPPC_PF_CNT_W     3
`define CPPC_PF_ROOM      3'h3
`define CPPC_ADDR_STEP    32'h00000004
`define CPPC_RESET_PC     32'h00000000
`define CPPC_STAGES_AREA  3
`define CPPC_STAGES_PERF  5

`endif

// *** hw/cppc_pkg.sv ***
// types shared by the pipeline and prefetch control block
package cppc_pkg;

    typedef logic [31:0] cppc_word_t;

    typedef enum logic [2:0]
    {
        CPPC_FE_IDLE = 3'b001,
        CPPC_FE_WAIT = 3'b010,
        CPPC_FE_DROP = 3'b100
    } cppc_fetch_state_e;

endpackage : cppc_pkg

// *** hw/cppc_prefetch_buf.sv ***
// instruction prefetch buffer holding sequential address and word pairs
`timescale 1ns/1ps
`include "cppc_regs.svh"

module cppc_prefetch_buf
    import cppc_pkg::*;
(
    // clock and reset
    input  wire logic                      clk,
    input  wire logic                      rstn,
    // fill side
    input  wire logic                      push,
    input  wire logic [`CPPC_ENTRY_W-1:0]  push_data,
    // drain side
    input  wire logic                      pop,
    output logic                           head_valid,
    output logic [`CPPC_ENTRY_W-1:0]       head_data,
    // control and state
    input  wire logic                      flush,
    output logic [`CPPC_PF_CNT_W-1:0]      count_q
);

    logic [`CPPC_ENTRY_W-1:0]  mem_q [`CPPC_PF_DEPTH];
    logic [`CPPC_PF_PTR_W-1:0] wr_q;
    logic [`CPPC_PF_PTR_W-1:0] wr_d;
    logic [`CPPC_PF_PTR_W-1:0] rd_q;
    logic [`CPPC_PF_PTR_W-1:0] rd_d;
    logic [`CPPC_PF_CNT_W-1:0] count_d;
    logic                      do_push;
    logic                      do_pop;

    assign head_valid = (count_q != 3'h0);
    assign head_data  = mem_q[rd_q];

    ////////////////////////////////////////////////////////////////////////////
    always_comb
    begin
        do_push = push && (count_q != 3'(`CPPC_PF_DEPTH)) && !flush;
        do_pop  = pop && head_valid && !flush;
        wr_d    = wr_q;
        rd_d    = rd_q;
        count_d = count_q;
        // (RULE6) flush empties buffer
        if (flush)
        begin
            wr_d    = 2'h0;
            rd_d    = 2'h0;
            count_d = 3'h0;
        end
        else
        begin
            if (do_push)
                wr_d = wr_q + 2'h1;
            if (do_pop)
                rd_d = rd_q + 2'h1;
            if (do_push && !do_pop)
                count_d = count_q + 3'h1;
            else if (do_pop && !do_push)
                count_d = count_q - 3'h1;
        end
    end

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            wr_q    <= 2'h0;
            rd_q    <= 2'h0;
            count_q <= 3'h0;
        end
        else
        begin
            wr_q    <= wr_d;
            rd_q    <= rd_d;
            count_q <= count_d;
        end
    end

    // storage needs no reset; count guards every read
    always_ff @(posedge clk)
    begin
        if (do_push)
            mem_q[wr_q] <= push_data;
    end

endmodule : cppc_prefetch_buf

// *** hw/cppc_pipe_ctrl.sv ***
// pipeline advance, stall and instruction prefetch control
// Notes on behaviour
// (RULE1) single-cycle stages, one retire per cycle
// (RULE2) multi-cycle execute holds earlier stages
// (RULE3) slow fetch waits, pipeline state kept
// (RULE4) prefetch keeps fetching sequentially during stall
// (RULE5) fetch stage loads from buffer when present
// (RULE6) barrier or synchronizing branch empties buffer
// (RULE7) area mode: fetch, decode, execute
// (RULE8) performance mode: five stages to writeback
// (RULE9) decode enters execute after last execute cycle
`timescale 1ns/1ps
`include "cppc_regs.svh"

module cppc_pipe_ctrl
    import cppc_pkg::*;
#(
    parameter bit area_optimization_select = 1'b1
)
(
    // clock and reset
    input  wire logic        clk,
    input  wire logic        rstn,
    // instruction memory
    output logic             imem_req_q,
    output cppc_word_t       imem_addr_q,
    input  wire logic        imem_ack,
    input  wire cppc_word_t  imem_rdata,
    // execute stage status
    input  wire logic        ex_busy,
    input  wire logic        memory_barrier_instr,
    input  wire logic        immediate_branch_instr,
    input  wire cppc_word_t  restart_addr,
    // stage contents
    output logic             dec_valid_q,
    output cppc_word_t       dec_instr_q,
    output logic             ex_valid_q,
    output cppc_word_t       ex_instr_q,
    output cppc_word_t       ex_pc_q,
    output logic             retire_q,
    output logic [2:0]       prefetch_count_q
);

    cppc_fetch_state_e st_q;
    cppc_fetch_state_e st_d;
    logic              req_d;
    cppc_word_t        addr_d;
    cppc_word_t        pc_q;
    cppc_word_t        pc_d;
    logic              push;
    logic              pop;
    logic              buf_valid;
    logic [63:0]       buf_head;
    logic              stall;
    logic              ex_done;
    logic              flush;
    logic              room;
    logic              if_valid_q;
    logic              if_valid_d;
    cppc_word_t        if_instr_q;
    cppc_word_t        if_instr_d;
    cppc_word_t        if_pc_q;
    cppc_word_t        if_pc_d;
    cppc_word_t        dec_pc_q;
    cppc_word_t        dec_pc_d;
    logic              dec_valid_d;
    cppc_word_t        dec_instr_d;
    logic              ex_valid_d;
    cppc_word_t        ex_instr_d;
    cppc_word_t        ex_pc_d;
    logic              mem_valid_q;
    logic              mem_valid_d;
    logic              wb_valid_q;
    logic              wb_valid_d;
    logic              retire_d;

    function automatic cppc_word_t next_seq(input cppc_word_t a);
        next_seq = a + `CPPC_ADDR_STEP;
    endfunction : next_seq

    ////////////////////////////////////////////////////////////////////////////
    // (RULE2) stall while execute is busy
    assign stall   = ex_valid_q && ex_busy;
    assign ex_done = ex_valid_q && !ex_busy;
    // (RULE6) flush on barrier or sync branch
    assign flush   = ex_done && (memory_barrier_instr || immediate_branch_instr);
    // one request in flight, so keep a slot for its answer
    assign room    = (prefetch_count_q < `CPPC_PF_ROOM);

    ////////////////////////////////////////////////////////////////////////////
    always_comb
    begin
        st_d   = st_q;
        req_d  = imem_req_q;
        addr_d = imem_addr_q;
        pc_d   = pc_q;
        push   = 1'b0;
        case (st_q)
            CPPC_FE_IDLE:
            begin
                if (flush)
                    pc_d = restart_addr;
                // (RULE4) fetch ahead even while stalled
                else if (room)
                begin
                    req_d  = 1'b1;
                    addr_d = pc_q;
                    st_d   = CPPC_FE_WAIT;
                end
            end
            CPPC_FE_WAIT:
            begin
                // (RULE3) hold request until answer
                if (imem_ack)
                begin
                    req_d = 1'b0;
                    push  = !flush;
                    pc_d  = flush ? restart_addr : next_seq(pc_q);
                    st_d  = CPPC_FE_IDLE;
                end
                else if (flush)
                begin
                    pc_d = restart_addr;
                    st_d = CPPC_FE_DROP;
                end
            end
            CPPC_FE_DROP:
            begin
                // stale word discarded; request cannot be withdrawn
                if (flush)
                    pc_d = restart_addr;
                if (imem_ack)
                begin
                    req_d = 1'b0;
                    st_d  = CPPC_FE_IDLE;
                end
            end
            default:
            begin
                st_d  = CPPC_FE_IDLE;
                req_d = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            st_q        <= CPPC_FE_IDLE;
            imem_req_q  <= 1'b0;
            imem_addr_q <= `CPPC_RESET_PC;
            pc_q        <= `CPPC_RESET_PC;
        end
        else
        begin
            st_q        <= st_d;
            imem_req_q  <= req_d;
            imem_addr_q <= addr_d;
            pc_q        <= pc_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    cppc_prefetch_buf u_buf
    (
        .clk        (clk),
        .rstn       (rstn),
        .push       (push),
        .push_data  ({imem_addr_q, imem_rdata}),
        .pop        (pop),
        .head_valid (buf_valid),
        .head_data  (buf_head),
        .flush      (flush),
        .count_q    (prefetch_count_q)
    );

    ////////////////////////////////////////////////////////////////////////////
    always_comb
    begin
        // (RULE5) refill fetch stage from buffer
        pop         = !flush && buf_valid && (!stall || !if_valid_q);
        if_valid_d  = if_valid_q;
        if_instr_d  = if_instr_q;
        if_pc_d     = if_pc_q;
        dec_valid_d = dec_valid_q;
        dec_instr_d = dec_instr_q;
        dec_pc_d    = dec_pc_q;
        ex_valid_d  = ex_valid_q;
        ex_instr_d  = ex_instr_q;
        ex_pc_d     = ex_pc_q;
        // (RULE1) every stage moves each cycle unless execute stalls
        if (!stall)
        begin
            if_valid_d  = 1'b0;
            // (RULE9) decode enters execute next cycle
            dec_valid_d = if_valid_q;
            dec_instr_d = if_instr_q;
            dec_pc_d    = if_pc_q;
            ex_valid_d  = dec_valid_q;
            ex_instr_d  = dec_instr_q;
            ex_pc_d     = dec_pc_q;
        end
        if (pop)
        begin
            if_valid_d = 1'b1;
            if_instr_d = buf_head[31:0];
            if_pc_d    = buf_head[63:32];
        end
        // (RULE6) younger stages discarded with buffer
        if (flush)
        begin
            if_valid_d  = 1'b0;
            dec_valid_d = 1'b0;
            ex_valid_d  = 1'b0;
        end
        // (RULE7) area mode retires from execute
        // (RULE8) performance mode adds memory, writeback
        mem_valid_d = area_optimization_select ? 1'b0 : ex_done;
        wb_valid_d  = area_optimization_select ? 1'b0 : mem_valid_q;
        retire_d    = area_optimization_select ? ex_done : wb_valid_q;
    end

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            if_valid_q  <= 1'b0;
            if_instr_q  <= 32'h00000000;
            if_pc_q     <= 32'h00000000;
            dec_valid_q <= 1'b0;
            dec_instr_q <= 32'h00000000;
            dec_pc_q    <= 32'h00000000;
            ex_valid_q  <= 1'b0;
            ex_instr_q  <= 32'h00000000;
            ex_pc_q     <= 32'h00000000;
            mem_valid_q <= 1'b0;
            wb_valid_q  <= 1'b0;
            retire_q    <= 1'b0;
        end
        else
        begin
            if_valid_q  <= if_valid_d;
            if_instr_q  <= if_instr_d;
            if_pc_q     <= if_pc_d;
            dec_valid_q <= dec_valid_d;
            dec_instr_q <= dec_instr_d;
            dec_pc_q    <= dec_pc_d;
            ex_valid_q  <= ex_valid_d;
            ex_instr_q  <= ex_instr_d;
            ex_pc_q     <= ex_pc_d;
            mem_valid_q <= mem_valid_d;
            wb_valid_q  <= wb_valid_d;
            retire_q    <= retire_d;
        end
    end

endmodule : cppc_pipe_ctrl

// *** tb/cppc_pipe_ctrl_properties.sv ***
// concurrent checks on the pipeline and prefetch control ports
`timescale 1ns/1ps

module cppc_pipe_ctrl_properties
    import cppc_pkg::*;
#(
    parameter bit area_optimization_select = 1'b1
)
(
    // clock and reset
    input wire logic       clk,
    input wire logic       rstn,
    // instruction memory
    input wire logic       imem_req_q,
    input wire cppc_word_t imem_addr_q,
    input wire logic       imem_ack,
    // execute stage status
    input wire logic       ex_busy,
    input wire logic       memory_barrier_instr,
    input wire logic       immediate_branch_instr,
    input wire cppc_word_t restart_addr,
    // stage contents
    input wire logic       dec_valid_q,
    input wire cppc_word_t dec_instr_q,
    input wire logic       ex_valid_q,
    input wire cppc_word_t ex_instr_q,
    input wire cppc_word_t ex_pc_q,
    input wire logic       retire_q,
    input wire logic [2:0] prefetch_count_q
);
    logic       flush, req_q, fl_q, fl_d;
    cppc_word_t nxt_q, nxt_d;

    ////////////////////////////////////////////////////////////////////////////////
    // expected next sequential address, skipped once after a flush
    assign flush = ex_valid_q && !ex_busy && (memory_barrier_instr || immediate_branch_instr);

    always_comb
    begin
        fl_d  = flush || (fl_q && !(imem_req_q && !req_q));
        nxt_d = (imem_req_q && imem_ack) ? imem_addr_q + 32'h00000004 : nxt_q;
    end

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            req_q <= 1'b0;
            fl_q  <= 1'b0;
            nxt_q <= 32'h00000000;
        end
        else
        begin
            req_q <= imem_req_q;
            fl_q  <= fl_d;
            nxt_q <= nxt_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    chk_req_stands: assert property (
        imem_req_q && !imem_ack |=> imem_req_q && $stable(imem_addr_q))
        else $error("fetch request changed before its answer");
    chk_req_drops: assert property (
        imem_req_q && imem_ack |=> !imem_req_q)
        else $error("fetch request stayed high after answer");
    chk_stall_holds: assert property (
        ex_valid_q && ex_busy && dec_valid_q |=> dec_valid_q && $stable(dec_instr_q)
        && $stable(ex_pc_q))
        else $error("stage moved during stall");
    chk_dec_advance: assert property (
        ex_valid_q && !ex_busy && dec_valid_q && !flush |=> ex_valid_q
        && ex_instr_q == $past(dec_instr_q))
        else $error("decode did not enter execute");
    chk_retire_next: assert property (
        area_optimization_select && ex_valid_q && !ex_busy && !flush |=> retire_q)
        else $error("missing retire pulse");
    chk_flush_empties: assert property (
        flush |=> prefetch_count_q == 3'h0 && !dec_valid_q && !ex_valid_q)
        else $error("flush left stale contents");
    chk_refetch_soon: assert property (
        !imem_req_q && prefetch_count_q < 3'h3 |-> ##[1:2] imem_req_q)
        else $error("prefetch stopped with room left");
    chk_seq_addr: assert property (
        $rose(imem_req_q) && !fl_q |-> imem_addr_q == nxt_q)
        else $error("fetch address not sequential");
    chk_perf_retire: assert property (
        !area_optimization_select && ex_valid_q && !ex_busy |=> ##2 retire_q)
        else $error("five-stage retire missing after writeback");

    cov_stall_full: cover property (ex_valid_q && ex_busy && prefetch_count_q == 3'h3);
    cov_flush: cover property (flush);
    cov_held_dec: cover property (ex_valid_q && ex_busy && dec_valid_q);
    cov_slow: cover property (imem_req_q && !imem_ack [*4] ##1 imem_ack);

endmodule : cppc_pipe_ctrl_properties

bind cppc_pipe_ctrl cppc_pipe_ctrl_properties
    #(.area_optimization_select(area_optimization_select)) cppc_pipe_ctrl_properties_inst (
    .clk(clk), .rstn(rstn), .imem_req_q(imem_req_q), .imem_addr_q(imem_addr_q),
    .imem_ack(imem_ack), .ex_busy(ex_busy), .memory_barrier_instr(memory_barrier_instr),
    .immediate_branch_instr(immediate_branch_instr), .restart_addr(restart_addr),
    .dec_valid_q(dec_valid_q), .dec_instr_q(dec_instr_q), .ex_valid_q(ex_valid_q),
    .ex_instr_q(ex_instr_q), .ex_pc_q(ex_pc_q), .retire_q(retire_q),
    .prefetch_count_q(prefetch_count_q));

// *** tb/cppc_imem_model.sv ***
// instruction memory model with a programmable answer delay
`timescale 1ns/1ps

module cppc_imem_model
    import cppc_pkg::*;
(
    // clock and reset
    input wire logic       clk,
    input wire logic       rstn,
    // fetch port
    input wire logic       req,
    input wire cppc_word_t addr,
    input wire logic [7:0] lat,
    output logic           ack,
    output cppc_word_t     rdata
);
    int wait_q;

    ////////////////////////////////////////////////////////////////////////////////
    // slow answer after lat cycles
    // word is the inverted address; data keeps toggling when not answering
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            ack    <= 1'b0;
            wait_q <= 0;
            rdata  <= 32'h00000000;
        end
        else if (req && !ack && wait_q >= int'(lat))
        begin
            ack   <= 1'b1;
            rdata <= ~addr;
        end
        else
        begin
            ack    <= 1'b0;
            wait_q <= (req && !ack) ? wait_q + 1 : 0;
            rdata  <= ~rdata;
        end
    end

endmodule : cppc_imem_model

// *** tb/tb.sv ***
// testbench for the pipeline and prefetch control block
`timescale 1ns/1ps

module tb
    import cppc_pkg::*;
;
    logic       clk, rstn, req, ack, busy, mb, br, dv, ev, ret, ret_perf;
    cppc_word_t addr, rdata, rst_a, di, ei, epc, p;
    logic [2:0] cnt;
    logic [7:0] lat;
    int         err_count, num_checks, i;

    cppc_pipe_ctrl #(.area_optimization_select(1'b1)) cppc_pipe_ctrl_inst (
        .clk(clk), .rstn(rstn), .imem_req_q(req), .imem_addr_q(addr), .imem_ack(ack),
        .imem_rdata(rdata), .ex_busy(busy), .memory_barrier_instr(mb),
        .immediate_branch_instr(br), .restart_addr(rst_a), .dec_valid_q(dv),
        .dec_instr_q(di), .ex_valid_q(ev), .ex_instr_q(ei), .ex_pc_q(epc),
        .retire_q(ret), .prefetch_count_q(cnt));

    // five-stage copy on the same stimulus; only its retire timing differs
    cppc_pipe_ctrl #(.area_optimization_select(1'b0)) cppc_pipe_ctrl_perf_inst (
        .clk(clk), .rstn(rstn), .imem_req_q(), .imem_addr_q(), .imem_ack(ack),
        .imem_rdata(rdata), .ex_busy(busy), .memory_barrier_instr(mb),
        .immediate_branch_instr(br), .restart_addr(rst_a), .dec_valid_q(),
        .dec_instr_q(), .ex_valid_q(), .ex_instr_q(), .ex_pc_q(),
        .retire_q(ret_perf), .prefetch_count_q());

    cppc_imem_model cppc_imem_model_inst (.clk(clk), .rstn(rstn), .req(req), .addr(addr),
        .lat(lat), .ack(ack), .rdata(rdata));

    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            err_count++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk

    // sample 1 ns after the edge so design updates have landed
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : step

    task automatic wait_ex(input cppc_word_t old);
        i = 0;
        while ((ev !== 1'b1 || epc === old) && i < 200)
        begin
            step(1);
            i++;
        end
        chk(ev, 1'b1);
    endtask : wait_ex

    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_startup();
        i = 0;
        while (ack !== 1'b1 && i < 50)
        begin
            step(1);
            i++;
        end
        step(3);
        chk({dv, ev}, 2'b10);
        step(1);
        chk(epc, 32'h00000000);
        chk(ei, 32'hFFFFFFFF);
        step(1);
        chk(ret, 1'b1);
    endtask : t_startup

    task automatic t_stall();
        @(posedge clk) busy <= 1'b1;
        step(1);
        chk({ret, ret_perf}, 2'b01);
        wait_ex(32'hFFFFFFFF);
        p = epc;
        step(12);
        chk(epc, p);
        chk(cnt, 3'h3);
        @(posedge clk) busy <= 1'b0;
        step(1);
        chk(ret, 1'b1);
        // stall the next one too, with its successor held in decode
        @(posedge clk) busy <= 1'b1;
        #1;
        chk(epc, p + 4);
        chk(dv, 1'b1);
        step(3);
        chk(epc, p + 4);
        chk(di, ~(p + 8));
        @(posedge clk) busy <= 1'b0;
        step(1);
        chk(epc, p + 8);
        chk(ret, 1'b1);
    endtask : t_stall

    task automatic t_slow();
        @(posedge clk) lat <= 8'h05;
        #1;
        // first words still come from the buffer, later ones wait on memory
        for (int k = 0; k < 6; k++)
        begin
            p = epc;
            wait_ex(p);
            chk(epc, p + 4);
            chk(ei, ~(p + 4));
        end
        @(posedge clk) lat <= 8'h00;
    endtask : t_slow

    // barrier first, then the synchronizing branch, each with a full buffer
    task automatic t_flush();
        for (int k = 0; k < 2; k++)
        begin
            @(posedge clk) busy <= 1'b1;
            step(1);
            wait_ex(32'hFFFFFFFF);
            step(12);
            @(posedge clk);
            busy  <= 1'b0;
            mb    <= (k == 0);
            br    <= (k == 1);
            rst_a <= 32'h00000100 << k;
            @(posedge clk);
            mb <= 1'b0;
            br <= 1'b0;
            #1;
            chk({dv, ev, cnt}, 32'h0);
            wait_ex(32'hFFFFFFFF);
            chk(epc, 32'h00000100 << k);
            chk(ei, ~(32'h00000100 << k));
        end
    endtask : t_flush

    task automatic tally_and_finish();
        $display("checks %0d errors %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : tally_and_finish

    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    initial
    begin
        #20000;
        err_count++;
        tally_and_finish();
    end

    initial
    begin
        rstn = 1'b0;
        busy = 1'b0;
        mb = 1'b0;
        br = 1'b0;
        rst_a = 32'h00000000;
        lat = 8'h00;
        err_count = 0;
        num_checks = 0;
        repeat (3) @(posedge clk);
        rstn <= 1'b1;
        t_startup();
        t_stall();
        t_slow();
        t_flush();
        tally_and_finish();
    end

endmodule : tb
